/* icyc_map.svh */
// Purpose: Constants for the instruction cycle timing sequencer
// Assumes: Counts are periods of the master clock
// Notes: Format column and addressing row pick each shift/push/call count; return and jump counts come from the format alone
// Contract
// [RULE1] Cycle count from format and addressing only
// [RULE2] All counts in master clock periods
// [RULE3] Return from interrupt: one word, 5 cycles
// [RULE4] Interrupt entry overhead takes 6 cycles
// [RULE5] Watchdog or pin reset: 4 cycles
// [RULE6] Register mode: 1 word; 1/3/4 cycles
// [RULE7] Indirect mode: 1 word; 3/4/4 cycles
// [RULE8] Autoincrement mode: 1 word; 3/5/5 cycles
// [RULE9] Immediate push/call: 2 words; 4/5 cycles
// [RULE10] Indexed/symbolic/absolute: 2 words; 4/5/5 cycles
// [RULE11] Software never uses immediate with shift group
// [RULE12] Jumps: one word, two cycles always
`ifndef ICYC_MAP_SVH
`define ICYC_MAP_SVH
`define ICYC_CYC_RETURN_FROM_INTERRUPT    4'h5
`define ICYC_CYC_IRQ     4'h6
`define ICYC_CYC_RST     4'h4
`define ICYC_CYC_JUMP    4'h2
`define ICYC_CYC_SH_REG  4'h1
`define ICYC_CYC_SH_MEM  4'h3
`define ICYC_CYC_SH_IDX  4'h4
`define ICYC_CYC_SH_BAD  4'h1
`define ICYC_CYC_PU_REG  4'h3
`define ICYC_CYC_CA_REG  4'h4
`define ICYC_CYC_PC_IND  4'h4
`define ICYC_CYC_PC_AINC 4'h5
`define ICYC_CYC_PU_IMM  4'h4
`define ICYC_CYC_CA_IMM  4'h5
`define ICYC_CYC_PC_IDX  4'h5
`define ICYC_LEN_ONE     2'h1
`define ICYC_LEN_TWO     2'h2
`define ICYC_CNT_W       4
`endif

/* icyc_pkg.sv */
// Purpose: Types for the instruction cycle timing sequencer
// Assumes: Nothing imported by users
// Notes: Addressing modes follow the two-bit mode field plus register
package icyc_pkg;
	typedef enum logic [2:0] {
		ICYC_AM_REG  = 3'h0,
		ICYC_AM_IND  = 3'h1,
		ICYC_AM_AINC = 3'h2,
		ICYC_AM_IMM  = 3'h3,
		ICYC_AM_IDX  = 3'h4
	} icyc_am_t;
	typedef enum logic [3:0] {
		ICYC_OP_SHIFT = 4'h0, // rotate/swap/sign extend group
		ICYC_OP_PUSH  = 4'h1,
		ICYC_OP_CALL  = 4'h2,
		ICYC_OP_RETURN_FROM_INTERRUPT  = 4'h3,
		ICYC_OP_JUMP  = 4'h4
	} icyc_op_t;
	typedef enum logic [3:0] {
		ICYC_ST_IDLE = 4'h1,
		ICYC_ST_BUSY = 4'h2,
		ICYC_ST_RST  = 4'h4,
		ICYC_ST_IRQ  = 4'h8
	} icyc_st_t;
	typedef struct packed {
		icyc_op_t  op;
		icyc_am_t  am;
	} icyc_req_t;
	typedef struct packed {
		logic [1:0] words;
		logic [3:0] cycles;
		logic       bad;
	} icyc_cost_t;
	typedef struct packed {
		icyc_st_t   st;
		logic [3:0] cnt;
		logic       done;
		icyc_cost_t cost;
		logic [1:0] rst_sync;
	} icyc_state_t;
endpackage

/* icyc_cost.sv */
// Purpose: Cycle and length lookup per format and addressing mode
// Assumes: Combinational, same clock domain as the caller
// Notes: Operation identity only selects the format column
`timescale 1ns/1ns
`include "icyc_map.svh"
module icyc_cost (
	input  wire icyc_pkg::icyc_req_t  req_i,  // Decoded format and mode
	output icyc_pkg::icyc_cost_t      cost_o  // Cycles, words, illegal flag
);
	// Table lookup; no opcode bits beyond the column enter here
	always_comb begin
		cost_o = '{words: `ICYC_LEN_ONE, cycles: 4'h1, bad: 1'b0}; // [RULE1]
		unique case (req_i.op)
			icyc_pkg::ICYC_OP_RETURN_FROM_INTERRUPT: cost_o.cycles = `ICYC_CYC_RETURN_FROM_INTERRUPT; // [RULE3]
			icyc_pkg::ICYC_OP_JUMP: cost_o.cycles = `ICYC_CYC_JUMP; // [RULE12]
			icyc_pkg::ICYC_OP_SHIFT: begin
				unique case (req_i.am)
					icyc_pkg::ICYC_AM_REG:  cost_o.cycles = `ICYC_CYC_SH_REG; // [RULE6]
					icyc_pkg::ICYC_AM_IND,
					icyc_pkg::ICYC_AM_AINC: cost_o.cycles = `ICYC_CYC_SH_MEM; // [RULE7] [RULE8]
					icyc_pkg::ICYC_AM_IMM: begin
						cost_o.cycles = `ICYC_CYC_SH_BAD; // Flagged, timing arbitrary [RULE11]
						cost_o.bad    = 1'b1;
					end
					default: begin
						cost_o.cycles = `ICYC_CYC_SH_IDX; // [RULE10]
						cost_o.words  = `ICYC_LEN_TWO;
					end
				endcase
			end
			default: begin // Push and call
				unique case (req_i.am)
					icyc_pkg::ICYC_AM_REG:
						cost_o.cycles = (req_i.op == icyc_pkg::ICYC_OP_CALL) ? `ICYC_CYC_CA_REG : `ICYC_CYC_PU_REG; // [RULE6]
					icyc_pkg::ICYC_AM_IND:  cost_o.cycles = `ICYC_CYC_PC_IND; // [RULE7]
					icyc_pkg::ICYC_AM_AINC: cost_o.cycles = `ICYC_CYC_PC_AINC; // [RULE8]
					icyc_pkg::ICYC_AM_IMM: begin
						cost_o.cycles = (req_i.op == icyc_pkg::ICYC_OP_CALL) ? `ICYC_CYC_CA_IMM : `ICYC_CYC_PU_IMM; // [RULE9]
						cost_o.words  = `ICYC_LEN_TWO;
					end
					default: begin
						cost_o.cycles = `ICYC_CYC_PC_IDX; // [RULE10]
						cost_o.words  = `ICYC_LEN_TWO;
					end
				endcase
			end
		endcase
	end
endmodule // icyc_cost

/* icyc_seq.sv */
// Purpose: Sequences instruction, interrupt and reset overhead in master clocks
// Assumes: Decoder presents one request with start_i; pin reset is asynchronous
// Notes: Resets outrank interrupts, which outrank instructions
`timescale 1ns/1ns
`include "icyc_map.svh"
module icyc_seq (
	input  wire logic               mclk_i,      // Master clock, 10 MHz
	input  wire logic               rst_i,       // Synchronous reset, high
	input  wire logic               ce_i,        // Clock enable, freezes state
	input  wire icyc_pkg::icyc_req_t req_i,      // Format and mode of instruction
	input  wire logic               start_i,     // Begin instruction, same domain
	input  wire logic               irq_i,       // Interrupt accepted, same domain
	input  wire logic               wdt_rst_i,   // Watchdog reset request
	input  wire logic               pin_rst_i,   // Reset pin level, async
	output logic                    ready_o,     // Idle, may start
	output logic                    done_o,      // One-cycle end of sequence
	output logic [1:0]              words_o,     // Code words of last instruction
	output logic [3:0]              cycles_o,    // Cycle count of last instruction
	output logic                    illegal_o    // Immediate used with shift group
);
	icyc_pkg::icyc_state_t s_q, s_d;
	icyc_pkg::icyc_cost_t  cost;
	logic                  pin_s3_q;
	logic                  pin_rst;

	icyc_cost u_cost (
		.req_i  (req_i),
		.cost_o (cost)
	);

	// Third stage of the pin synchroniser; only stage two and three are compared
	always_ff @(posedge mclk_i) begin
		if (rst_i)
			pin_s3_q <= 1'b0;
		else if (ce_i)
			pin_s3_q <= s_q.rst_sync[1];
	end
	assign pin_rst = s_q.rst_sync[1] & pin_s3_q;

	// Next state: counter loads cost minus one so a count of N lasts N clocks
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.rst_sync = {s_q.rst_sync[0], pin_rst_i};
		unique case (s_q.st)
			icyc_pkg::ICYC_ST_IDLE: begin
				if (wdt_rst_i || pin_rst) begin
					s_d.st  = icyc_pkg::ICYC_ST_RST;
					s_d.cnt = `ICYC_CYC_RST - 4'h1; // [RULE5]
				end else if (irq_i) begin
					s_d.st  = icyc_pkg::ICYC_ST_IRQ;
					s_d.cnt = `ICYC_CYC_IRQ - 4'h1; // [RULE4]
				end else if (start_i) begin
					s_d.st   = icyc_pkg::ICYC_ST_BUSY;
					s_d.cost = cost;
					s_d.cnt  = cost.cycles - 4'h1; // [RULE2]
				end
			end
			default: begin
				if ((wdt_rst_i || pin_rst) && s_q.st != icyc_pkg::ICYC_ST_RST) begin
					s_d.st  = icyc_pkg::ICYC_ST_RST;
					s_d.cnt = `ICYC_CYC_RST - 4'h1; // [RULE5]
				end else if (s_q.cnt == 4'h0) begin
					s_d.st   = icyc_pkg::ICYC_ST_IDLE;
					s_d.done = 1'b1;
				end else
					s_d.cnt = s_q.cnt - 4'h1;
			end
		endcase
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge mclk_i) begin
		if (rst_i)
			s_q <= '{st: icyc_pkg::ICYC_ST_IDLE, cnt: 4'h0, done: 1'b0,
			         cost: '{words: 2'h0, cycles: 4'h0, bad: 1'b0}, rst_sync: 2'h0};
		else if (ce_i)
			s_q <= s_d;
	end

	// Handshake output combinational, data outputs straight from flops
	assign ready_o   = (s_q.st == icyc_pkg::ICYC_ST_IDLE);
	assign done_o    = s_q.done;
	assign words_o   = s_q.cost.words;
	assign cycles_o  = s_q.cost.cycles;
	assign illegal_o = s_q.cost.bad;

	// Count cycles spent busy to check totals
	logic [3:0] run_q;
	always_ff @(posedge mclk_i) begin
		if (rst_i || ready_o)
			run_q <= 4'h1;
		else if (ce_i)
			run_q <= run_q + 4'h1;
	end

	chk_return_from_interrupt_len: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE3]
		(ce_i && ready_o && start_i && !irq_i && !wdt_rst_i && !pin_rst && req_i.op == icyc_pkg::ICYC_OP_RETURN_FROM_INTERRUPT)
		|=> cycles_o == 4'h5 && words_o == 2'h1) else $error("return_from_interrupt cost wrong");
	chk_jump_len: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE12]
		(ce_i && ready_o && start_i && !irq_i && !wdt_rst_i && !pin_rst && req_i.op == icyc_pkg::ICYC_OP_JUMP)
		|=> cycles_o == 4'h2 && words_o == 2'h1) else $error("jump cost wrong");
	chk_irq_span: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE4]
		(s_q.st == icyc_pkg::ICYC_ST_IRQ && s_q.cnt == 4'h0) |-> run_q == 4'h6) else $error("irq span");
	chk_rst_count: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE5]
		(ce_i && ready_o && wdt_rst_i) |=> s_q.st == icyc_pkg::ICYC_ST_RST && s_q.cnt == 4'h3) else $error("reset count");
	chk_shift_reg: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE6]
		(req_i.op == icyc_pkg::ICYC_OP_SHIFT && req_i.am == icyc_pkg::ICYC_AM_REG) |-> cost.cycles == 4'h1) else $error("shift reg");
	chk_push_ind: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE7]
		(req_i.op == icyc_pkg::ICYC_OP_PUSH && req_i.am == icyc_pkg::ICYC_AM_IND) |-> cost.cycles == 4'h4) else $error("push ind");
	chk_call_ainc: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE8]
		(req_i.op == icyc_pkg::ICYC_OP_CALL && req_i.am == icyc_pkg::ICYC_AM_AINC) |-> cost.cycles == 4'h5) else $error("call ainc");
	chk_call_imm: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE9]
		(req_i.op == icyc_pkg::ICYC_OP_CALL && req_i.am == icyc_pkg::ICYC_AM_IMM) |-> cost.cycles == 4'h5 && cost.words == 2'h2)
		else $error("call imm");
	chk_shift_idx: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE10]
		(req_i.op == icyc_pkg::ICYC_OP_SHIFT && req_i.am == icyc_pkg::ICYC_AM_IDX) |-> cost.cycles == 4'h4 && cost.words == 2'h2)
		else $error("shift idx");
	chk_done_time: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE2]
		(ce_i && ready_o && start_i && !irq_i && !wdt_rst_i && !pin_rst && req_i.op == icyc_pkg::ICYC_OP_JUMP)
		##1 ce_i [*2] |=> done_o) else $error("jump end late");
	cov_irq: cover property (@(posedge mclk_i) s_q.st == icyc_pkg::ICYC_ST_IRQ ##[1:8] done_o);
	cov_rst: cover property (@(posedge mclk_i) s_q.st == icyc_pkg::ICYC_ST_RST ##[1:8] done_o);
	cov_bad: cover property (@(posedge mclk_i) illegal_o);
	cov_abort: cover property (@(posedge mclk_i) ce_i && s_q.st == icyc_pkg::ICYC_ST_BUSY && wdt_rst_i);
	cov_freeze: cover property (@(posedge mclk_i) !ce_i && s_q.st == icyc_pkg::ICYC_ST_BUSY);

	// A pulse, not a level: idle can never end a sequence on the very next edge
	chk_done_pulse: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE2]
		(ce_i && done_o) |=> !done_o) else $error("done longer than one cycle");
	// Requests are refused while busy, so the shown cost must not move
	chk_busy_hold: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE1]
		(ce_i && !ready_o) |=> $stable(cycles_o) && $stable(words_o)) else $error("cost changed while busy");
	// A watchdog request cuts short any running instruction or interrupt sequence, but not a running reset sequence
	chk_rst_abort: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE5]
		(ce_i && !ready_o && s_q.st != icyc_pkg::ICYC_ST_RST && wdt_rst_i)
		|=> s_q.st == icyc_pkg::ICYC_ST_RST && s_q.cnt == 4'h3) else $error("reset did not abort");
	// Disabled clocks must not count toward any sequence
	chk_freeze: assert property (@(posedge mclk_i) disable iff (rst_i) // [RULE2]
		!ce_i |=> $stable(s_q)) else $error("state moved while disabled");
endmodule // icyc_seq

/* icyc_fetch_model.sv */
// Purpose: Decoder-side model that hands requests to the sequencer
// Assumes: Request lines change at the falling edge only
// Notes: Released request lines show the inverse of the last value
`timescale 1ns/1ns
module icyc_fetch_model (
	input  wire logic           mclk_i,  // Master clock
	input  wire logic           ready_i, // Sequencer idle
	output logic                start_o, // Request strobe
	output icyc_pkg::icyc_req_t req_o    // Format and mode
);
	// Hold the request until an edge samples ready high; gap models a slow fetch
	task automatic issue(input icyc_pkg::icyc_req_t r, input int gap);
		repeat (gap) @(negedge mclk_i);
		start_o = 1'b1;
		req_o   = r; // Immediate shift only when the bench asks
		do @(posedge mclk_i); while (ready_i !== 1'b1);
		@(negedge mclk_i);
		start_o = 1'b0;
		req_o   = ~r; // A stale bus never mirrors the last word
	endtask
	// Quiet bus at time zero
	initial begin
		start_o = 1'b0;
		req_o   = '0;
	end
endmodule // icyc_fetch_model

/* cpu_instruction_cycle_timing_test.sv */
// Purpose: Self-checking bench for the cycle timing sequencer
// Assumes: Inputs change on the falling edge of a 10 MHz clock
// Notes: Pin reset latency includes the three-stage synchroniser
`timescale 1ns/1ns
module cpu_instruction_cycle_timing_test;
	logic                mclk_i = 1'b0;
	logic                rst_i = 1'b1, irq_i = 1'b0, wdt_rst_i = 1'b0, pin_rst_i = 1'b0;
	logic                ready_o, done_o, illegal_o, start;
	logic                ce = 1'b1;
	logic [1:0]          words_o;
	logic [3:0]          cycles_o;
	icyc_pkg::icyc_req_t req;
	int                  failures = 0, n_compared = 0, n;
	// Expected cycles: rows shift/push/call, columns by mode
	logic [3:0] cyc_tab [3][5] = '{'{4'h1, 4'h3, 4'h3, 4'h1, 4'h4}, '{4'h3, 4'h4, 4'h5, 4'h4, 4'h5},
		'{4'h4, 4'h4, 4'h5, 4'h5, 4'h5}};
	always #50 mclk_i = ~mclk_i;
	icyc_seq i_icyc_seq (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .req_i(req), .start_i(start),
		.irq_i(irq_i), .wdt_rst_i(wdt_rst_i), .pin_rst_i(pin_rst_i), .ready_o(ready_o), .done_o(done_o),
		.words_o(words_o), .cycles_o(cycles_o), .illegal_o(illegal_o));
	icyc_fetch_model i_icyc_fetch_model (.mclk_i(mclk_i), .ready_i(ready_o), .start_o(start), .req_o(req));
	// Four-state compare so an unknown never passes
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Cycles from the taking edge to the done pulse, bounded against a hang
	task automatic wait_done();
		n = 0;
		while (done_o !== 1'b1 && n < 20) begin
			@(negedge mclk_i);
			n++;
		end
		if (done_o !== 1'b1) begin
			failures++;
			$display("CHECK FAILED at %0t: done pulse never came", $time);
		end
	endtask
	// One instruction; single-cycle ones wait a cycle so the strobe is not rewritten in one step
	task automatic run(input logic [3:0] op, input logic [2:0] am, input logic [3:0] exp, input logic [1:0] w);
		logic bad;
		bad = (op == 4'h0) && (am == 3'h3);
		i_icyc_fetch_model.issue(icyc_pkg::icyc_req_t'({op, am}), int'(exp == 4'h1));
		chk({3'h0, ready_o}, 4'h0);
		chk(cycles_o, exp);
		if (!bad) chk({2'h0, words_o}, {2'h0, w});
		chk({3'h0, illegal_o}, {3'h0, bad});
		wait_done();
		chk(n[3:0], exp);
	endtask
	// Every format-II row and mode, back to back where the count allows
	task automatic t_single();
		for (int o = 0; o < 3; o++)
			for (int a = 0; a < 5; a++)
				run(o[3:0], a[2:0], cyc_tab[o][a], (a >= 3) ? 2'h2 : 2'h1);
	endtask
	// Return and jumps; a jump with an indexed mode field still costs two
	task automatic t_misc();
		run(4'h3, 3'h0, 4'h5, 2'h1);
		run(4'h4, 3'h0, 4'h2, 2'h1);
		run(4'h4, 3'h4, 4'h2, 2'h1);
	endtask
	// Interrupt refused while busy, then a watchdog reset cutting a call short
	task automatic t_abort();
		i_icyc_fetch_model.issue(icyc_pkg::icyc_req_t'({4'h2, 3'h4}), 0);
		irq_i = 1'b1;
		@(negedge mclk_i);
		irq_i = 1'b0;
		wait_done();
		chk(n[3:0], 4'h4);
		i_icyc_fetch_model.issue(icyc_pkg::icyc_req_t'({4'h2, 3'h4}), 0);
		wdt_rst_i = 1'b1;
		@(negedge mclk_i);
		wdt_rst_i = 1'b0;
		wait_done();
		chk(n[3:0], 4'h4);
	endtask
	// Clock enable low for three edges must stretch a push without counting them
	task automatic t_freeze();
		i_icyc_fetch_model.issue(icyc_pkg::icyc_req_t'({4'h1, 3'h0}), 0);
		ce = 1'b0;
		repeat (3) @(negedge mclk_i);
		chk({3'h0, ready_o}, 4'h0);
		ce = 1'b1;
		wait_done();
		chk(n[3:0], 4'h3);
	endtask
	// Interrupt, watchdog or pin reset; the pin needs two cycles to pass the synchroniser
	task automatic fire(input int sel, input logic [3:0] exp);
		@(negedge mclk_i);
		{pin_rst_i, wdt_rst_i, irq_i} = 3'h1 << sel;
		if (sel == 2) @(negedge mclk_i);
		@(negedge mclk_i);
		{pin_rst_i, wdt_rst_i, irq_i} = 3'h0;
		wait_done();
		if (sel == 2) chk({3'h0, n >= 4 && n <= 9}, 4'h1);
		else chk(n[3:0], exp);
	endtask
	task automatic tally_and_finish();
		$display("Compared %0d, failed %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (16) @(negedge mclk_i);
		rst_i = 1'b0;
		chk({ready_o, done_o, illegal_o, 1'b0}, 4'h8);
		t_single();
		t_misc();
		t_abort();
		t_freeze();
		fire(0, 4'h6);
		fire(1, 4'h4);
		fire(2, 4'h4);
		tally_and_finish();
	end
	// Watchdog: about 4000 cycles, far beyond the roughly 150 the tests need
	initial begin
		#400000;
		failures++;
		tally_and_finish();
	end
endmodule // cpu_instruction_cycle_timing_test
